// ---- include/iec_defs.svh ----
`ifndef IEC_DEFS_SVH
`define IEC_DEFS_SVH
// ************************************************************
// Comparator figures in millivolts
// ************************************************************
`define IEC_REF_MV 16'sd1500
`define IEC_HYST_MV 16'sd500
`define IEC_MV_W 16
// ************************************************************
// Counter layout
// ************************************************************
`define IEC_CNT_W 32
`define IEC_CNT_RST 32'h0000_0000
`define IEC_NUM_CH 4
`define IEC_MODE_SINGLE 1'b0
`define IEC_MODE_QUAD 1'b1
`endif

// ---- include/iec_pkg.sv ----
package iec_pkg;
   typedef enum logic [1:0] {
      IEC_TYPE_EVENT,
      IEC_TYPE_FREQ,
      IEC_TYPE_TIME,
      IEC_TYPE_POSITION
   } iec_meas_t;
   typedef enum logic {IEC_SYNC_WAIT, IEC_SYNC_RUN} iec_sync_t;
endpackage : iec_pkg

// ---- design/iec_detector.sv ----
`timescale 1ns/1ps
`include "iec_defs.svh"
module iec_detector (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic signed [15:0] level_mv,
   output logic det_out
);
   logic next_det;
   always_comb begin
      next_det = det_out;
      // Hysteresis keeps noise below its width from toggling
      if (!det_out && level_mv > `IEC_REF_MV + (`IEC_HYST_MV >>> 1))
         next_det = 1'b1; // RULE10 RULE11
      else if (det_out && level_mv < `IEC_REF_MV - (`IEC_HYST_MV >>> 1))
         next_det = 1'b0; // RULE10 RULE11
   end
   always_ff @(posedge ref_clk) begin
      if (rst)
         det_out <= 1'b0;
      else if (clk_en)
         det_out <= next_det;
   end
endmodule : iec_detector

// ---- design/iec_counter.sv ----
`timescale 1ns/1ps
`include "iec_defs.svh"
// Contract
// RULE1 - Counters stay inactive after start until first index rising edge.
// RULE2 - Index edge releases counters whatever the start trigger state. Here meas_start high holds counting low, loading IEC_SYNC_WAIT unless no_index_sel.
// RULE3 - Index detection re-arms at every measurement start.
// RULE4 - Sensor without index track needs the no-index option selected.
// RULE5 - Index input uses channel one comparator settings.
// RULE6 - Open index input reads high, and high is inactive.
// RULE7 - Quadrature direction comes from the A/B phase relation.
// RULE8 - Time and frequency results come only from the first track.
// RULE9 - Event, frequency and time types run single-track, no sign.
// RULE10 - Detector rises above ref plus half hysteresis, falls below minus.
// RULE11 - Reference 1.5 V, hysteresis 0.5 V: edges at 1.75 and 1.25 V.
// RULE12 - Four tracks act as four single or two quadrature channels.
// RULE13 - Quadrature channel 1 zeroes channel 2; channel 3 zeroes 4.
// RULE14 - Shared index gates all four counter channels together.
// RULE15 - Quadrature counts up one direction, down the other.
module iec_counter
   import iec_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic meas_start,
   input wire logic no_index_sel,
   input wire logic pair_12_quad,
   input wire logic pair_34_quad,
   input wire iec_pkg::iec_meas_t meas_type_1,
   input wire iec_pkg::iec_meas_t meas_type_3,
   input wire logic signed [15:0] track_mv_0,
   input wire logic signed [15:0] track_mv_1,
   input wire logic signed [15:0] track_mv_2,
   input wire logic signed [15:0] track_mv_3,
   input wire logic signed [15:0] index_mv,
   output logic [31:0] count_0,
   output logic [31:0] count_1,
   output logic [31:0] count_2,
   output logic [31:0] count_3,
   output logic dir_0,
   output logic dir_2,
   output logic counting,
   output logic [3:0] track_level
);
   import iec_pkg::*;

   // ************************************************************
   // Comparators
   // ************************************************************
   logic [3:0] det;
   logic idx_det;
   logic signed [15:0] mv [0:3];
   assign mv[0] = track_mv_0;
   assign mv[1] = track_mv_1;
   assign mv[2] = track_mv_2;
   assign mv[3] = track_mv_3;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_det
         iec_detector u_det (
            .ref_clk(ref_clk),
            .rst(rst),
            .clk_en(clk_en),
            .level_mv(mv[g]),
            .det_out(det[g])
         );
      end
   endgenerate

   // Index shares channel one comparator figures; idle level is high
   iec_detector u_idx ( // RULE5
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .level_mv(index_mv),
      .det_out(idx_det)
   );

   // ************************************************************
   // Index gating
   // ************************************************************
   iec_sync_t sync_st;
   iec_sync_t next_sync_st;
   logic idx_prev;
   logic next_idx_prev;
   logic idx_valid;
   logic next_idx_valid;

   always_comb begin
      next_sync_st = sync_st;
      // Detector leaves reset low; ignore it for one edge so an
      // open, idle-high index never looks like a rising edge
      next_idx_valid = 1'b1;
      next_idx_prev = idx_valid ? idx_det : 1'b1; // RULE6
      if (meas_start)
         next_sync_st = no_index_sel ? IEC_SYNC_RUN : IEC_SYNC_WAIT; // RULE3
      else begin
         unique case (sync_st)
            IEC_SYNC_WAIT: begin
               // Start trigger plays no part here
               if (idx_det && !idx_prev)
                  next_sync_st = IEC_SYNC_RUN; // RULE1 RULE2
               else if (no_index_sel)
                  next_sync_st = IEC_SYNC_RUN; // RULE4
            end
            IEC_SYNC_RUN: next_sync_st = IEC_SYNC_RUN;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync_st <= IEC_SYNC_WAIT;
         idx_prev <= 1'b1;
         idx_valid <= 1'b0;
      end else if (clk_en) begin
         sync_st <= next_sync_st;
         idx_prev <= next_idx_prev;
         idx_valid <= next_idx_valid;
      end
   end

   // One gate for all four channels
   assign counting = (sync_st == IEC_SYNC_RUN) && !meas_start; // RULE14

   // ************************************************************
   // Counting
   // ************************************************************
   logic [3:0] det_prev;
   logic [3:0] next_det_prev;
   logic [31:0] cnt [0:3];
   logic [31:0] next_cnt [0:3];
   logic dir_a;
   logic dir_c;
   logic next_dir_a;
   logic next_dir_c;
   logic quad_a;
   logic quad_c;

   // Only the position type may use direction
   assign quad_a = pair_12_quad && (meas_type_1 == IEC_TYPE_POSITION); // RULE9
   assign quad_c = pair_34_quad && (meas_type_3 == IEC_TYPE_POSITION); // RULE9

   // Rising first-track edge; direction from second track level
   function automatic logic [31:0] step(input logic [31:0] c,
                                        input logic rise,
                                        input logic quad,
                                        input logic b_lvl);
      if (!rise)
         step = c;
      else if (quad && b_lvl)
         step = c - 32'h0000_0001; // RULE15
      else
         step = c + 32'h0000_0001; // RULE8 RULE15
   endfunction : step

   always_comb begin
      next_det_prev = det;
      next_dir_a = dir_a;
      next_dir_c = dir_c;
      for (int i = 0; i < 4; i++)
         next_cnt[i] = cnt[i];
      if (meas_start) begin
         for (int i = 0; i < 4; i++)
            next_cnt[i] = `IEC_CNT_RST;
      end else if (counting) begin
         // Each track counts its own rising edges; B level gives the sign on first tracks only when quad_a or quad_c is set
         next_cnt[0] = step(cnt[0], det[0] && !det_prev[0], quad_a, det[1]);
         next_cnt[2] = step(cnt[2], det[2] && !det_prev[2], quad_c, det[3]);
         next_cnt[1] = step(cnt[1], det[1] && !det_prev[1], 1'b0, 1'b0);
         next_cnt[3] = step(cnt[3], det[3] && !det_prev[3], 1'b0, 1'b0);
         if (quad_a && det[0] && !det_prev[0])
            next_dir_a = det[1]; // RULE7
         if (quad_c && det[2] && !det_prev[2])
            next_dir_c = det[3]; // RULE7
      end
      // Paired second channels read zero
      if (pair_12_quad)
         next_cnt[1] = `IEC_CNT_RST; // RULE12 RULE13
      if (pair_34_quad)
         next_cnt[3] = `IEC_CNT_RST; // RULE12 RULE13
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         det_prev <= 4'h0;
         dir_a <= 1'b0;
         dir_c <= 1'b0;
         for (int i = 0; i < 4; i++)
            cnt[i] <= `IEC_CNT_RST;
      end else if (clk_en) begin
         det_prev <= next_det_prev;
         dir_a <= next_dir_a;
         dir_c <= next_dir_c;
         for (int i = 0; i < 4; i++)
            cnt[i] <= next_cnt[i];
      end
   end

   assign count_0 = cnt[0];
   assign count_1 = cnt[1];
   assign count_2 = cnt[2];
   assign count_3 = cnt[3];
   assign dir_0 = dir_a;
   assign dir_2 = dir_c;
   assign track_level = det;
endmodule : iec_counter

// ---- testbench/iec_counter_assertions.sv ----
`timescale 1ns/1ps
`include "iec_defs.svh"
module iec_counter_chk
   import iec_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic meas_start,
   input wire logic pair_12_quad,
   input wire logic pair_34_quad,
   input wire iec_pkg::iec_meas_t meas_type_1,
   input wire logic signed [15:0] track_mv_2,
   input wire logic [31:0] count_0,
   input wire logic [31:0] count_1,
   input wire logic [31:0] count_3,
   input wire logic dir_0,
   input wire logic counting,
   input wire logic [3:0] track_level
);
   localparam logic signed [15:0] HI = `IEC_REF_MV + (`IEC_HYST_MV >>> 1);
   localparam logic signed [15:0] LO = `IEC_REF_MV - (`IEC_HYST_MV >>> 1);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_level_rise: assert property (clk_en && track_mv_2 > HI
      |=> track_level[2]) else $error("rise missed");
   a_level_fall: assert property (clk_en && track_mv_2 < LO
      |=> !track_level[2]) else $error("fall missed");
   a_level_band: assert property (clk_en && track_mv_2 >= LO
      && track_mv_2 <= HI |=> $stable(track_level[2]))
      else $error("band moved");
   a_single_count: assert property (counting && clk_en
      && !pair_12_quad && $rose(track_level[0])
      |=> count_0 == $past(count_0) + 32'h1) else $error("single count");
   a_quad_dir: assert property (counting && clk_en && pair_12_quad
      && meas_type_1 == IEC_TYPE_POSITION && $rose(track_level[0])
      |=> dir_0 == $past(track_level[1]) && count_0 == $past(count_0)
      + ($past(track_level[1]) ? 32'hFFFF_FFFF : 32'h1))
      else $error("quad count");
   a_pair_zero_b: assert property (pair_12_quad
      && $past(pair_12_quad) && $past(clk_en) |-> count_1 == 32'h0)
      else $error("ch2 live");
   a_pair_zero_d: assert property (pair_34_quad
      && $past(pair_34_quad) && $past(clk_en) |-> count_3 == 32'h0)
      else $error("ch4 live");
   a_start_refuse: assert property (meas_start |-> !counting)
      else $error("counting at start");
endmodule : iec_counter_chk
bind iec_counter iec_counter_chk u_chk (.*);

// ---- testbench/iec_enc_model.sv ----
`timescale 1ns/1ps
module iec_enc_model (
   input wire logic ref_clk,
   input wire logic step,
   input wire logic rev,
   input wire logic idx_pulse,
   input wire logic idx_open,
   output logic signed [15:0] a_mv,
   output logic signed [15:0] b_mv,
   output logic signed [15:0] idx_mv
);
   logic [1:0] ph = 2'h0;
   // Gray phase keeps the tracks a quarter period apart
   // Advance on the sampling edge by NBA so step is never raced
   always @(posedge ref_clk) begin
      if (step) ph <= rev ? ph - 2'h1 : ph + 2'h1;
   end
   assign a_mv = ph[1] ? 16'sh0BB8 : 16'sh0000;
   assign b_mv = (ph[1] ^ ph[0]) ? 16'sh0BB8 : 16'sh0000;
   // Pulse just above threshold; open input floats high
   assign idx_mv = idx_open ? 16'sh1388 : idx_pulse ? 16'sh06D7 : 16'sh0;
endmodule : iec_enc_model

// ---- testbench/incremental_encoder_counter_test.sv ----
`timescale 1ns/1ps
module incremental_encoder_counter_test;
   import iec_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, meas_start = 1'b0;
   logic no_index_sel = 1'b0, pair_12_quad = 1'b0, pair_34_quad = 1'b0;
   logic step = 1'b0, rev = 1'b0, idx_pulse = 1'b0, idx_open = 1'b0;
   iec_meas_t meas_type_1 = IEC_TYPE_POSITION, meas_type_3 = IEC_TYPE_EVENT;
   logic signed [15:0] track_mv_0, track_mv_1, index_mv;
   logic signed [15:0] track_mv_2 = 16'sh0, track_mv_3 = 16'sh0;
   logic [31:0] count_0, count_1, count_2, count_3;
   logic dir_0, dir_2, counting;
   logic [3:0] track_level;
   logic signed [15:0] lv [4] = '{16'sh04E2, 16'sh04E1, 16'sh06D6, 16'sh06D7};
   logic [3:0] lx = 4'h9;
   int bad_count = 0, checked = 0;
   always #2 ref_clk = ~ref_clk;
   iec_counter dut (.*);
   iec_enc_model enc (.ref_clk(ref_clk), .step(step), .rev(rev),
      .idx_pulse(idx_pulse), .idx_open(idx_open), .a_mv(track_mv_0),
      .b_mv(track_mv_1), .idx_mv(index_mv));
   task automatic chk(input logic [31:0] seen, exp, input string what);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic run(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : run
   task automatic steps(input int n, input logic r);
      rev = r;
      step = 1'b1;
      run(n);
      step = 1'b0;
      run(4);
   endtask : steps
   task automatic start();
      meas_start = 1'b1;
      run(1);
      chk(counting, 32'h0, "counting");
      meas_start = 1'b0;
      run(1);
      chk(count_0, 32'h0, "count_0");
   endtask : start
   task automatic sync();
      idx_pulse = 1'b1;
      run(3);
      idx_pulse = 1'b0;
      run(1);
      chk(counting, 32'h1, "counting");
   endtask : sync
   task automatic summarize();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   initial begin
      run(2000);
      bad_count++;
      summarize();
   end
   initial begin
      run(12);
      rst = 1'b0;
      start();
      steps(4, 1'b0);
      chk(count_0, 32'h0, "held");
      sync();
      steps(4, 1'b0);
      track_mv_2 = 16'sh0BB8;
      run(4);
      chk(count_0, 32'h1, "count_0");
      chk(count_1, 32'h1, "count_1");
      chk(count_2, 32'h1, "count_2");
      start();
      steps(4, 1'b0);
      chk(counting, 32'h0, "rearm");
      sync();
      pair_12_quad = 1'b1;
      steps(4, 1'b0);
      chk(count_0, 32'hFFFF_FFFF, "down");
      chk(dir_0, 32'h1, "dir_0");
      chk(count_1, 32'h0, "count_1");
      steps(4, 1'b1);
      chk(count_0, 32'h0, "up");
      meas_type_1 = IEC_TYPE_EVENT;
      steps(4, 1'b0);
      chk(count_0, 32'h1, "event");
      no_index_sel = 1'b1;
      idx_open = 1'b1;
      start();
      chk(counting, 32'h1, "no_index");
      pair_34_quad = 1'b1;
      track_mv_3 = 16'sh0BB8;
      foreach (lv[i]) begin
         track_mv_2 = lv[i];
         run(2);
         chk(track_level[2], lx[i], "track_level");
      end
      chk(count_3, 32'h0, "count_3");
      chk(dir_2, 32'h0, "dir_2");
      clk_en = 1'b0;
      track_mv_2 = 16'sh0;
      run(3);
      chk(track_level[2], 32'h1, "frozen");
      clk_en = 1'b1;
      run(2);
      chk(track_level[2], 32'h0, "thawed");
      summarize();
   end
endmodule : incremental_encoder_counter_test
